// ==== cmp_pkg.sv ====
/*
 * Shared constants for the triple comparator control block: register
 * offsets, field positions, reset values and selector encodings.
 * Assumes a 32-bit APB register bus with one aligned word per register.
 */
package cmp_pkg;

	// ********************************************************
	// Register byte offsets
	// ********************************************************
	localparam logic [7:0] OFS_CTRL1 = 8'h00;
	localparam logic [7:0] OFS_CTRL2 = 8'h04;
	localparam logic [7:0] OFS_CTRL3 = 8'h08;
	localparam logic [7:0] OFS_STAT = 8'h0C;
	localparam logic [7:0] OFS_REFSEL = 8'h10;

	// ********************************************************
	// Reset values
	// ********************************************************
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] STAT_RESET = 16'h0000;
	localparam logic [15:0] REFSEL_RESET = 16'h0000;

	// ********************************************************
	// Control register fields
	// ********************************************************
	localparam int CMP_ON_BIT = 15;
	localparam int PIN_DRIVE_BIT = 14;
	localparam int INVERT_BIT = 13;
	localparam int EVENT_BIT = 9;
	localparam int RESULT_BIT = 8;
	localparam int EDGE_HI = 7;
	localparam int EDGE_LO = 6;
	localparam int PLUS_SEL_BIT = 4;
	localparam int MINUS_HI = 1;
	localparam int MINUS_LO = 0;
	// Bits software may store in a control register
	localparam logic [15:0] CTRL_WMASK = 16'hE0D3;

	// ********************************************************
	// Status and reference select fields
	// ********************************************************
	localparam int IDLE_HALT_BIT = 15;
	localparam int STAT_EVT_LO = 8;
	localparam int STAT_OUT_LO = 0;
	localparam int EXT_REF_BIT = 10;
	localparam int BG_SRC_HI = 9;
	localparam int BG_SRC_LO = 8;

	// ********************************************************
	// Encodings
	// ********************************************************
	localparam logic [1:0] EDGE_NONE = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_ANY = 2'h3;
	localparam logic [1:0] MINUS_PIN_B = 2'h0;
	localparam logic [1:0] MINUS_PIN_C = 2'h1;
	localparam logic [1:0] MINUS_PIN_D = 2'h2;
	localparam logic [1:0] MINUS_INT_REF = 2'h3;
	localparam logic [1:0] BG_FULL = 2'h0;
	localparam logic [1:0] BG_HALF = 2'h1;
	localparam logic [1:0] BG_SIXTH = 2'h2;
	localparam logic [1:0] BG_EXT_PIN = 2'h3;

	// One-hot source codes for the inverting input
	localparam logic [6:0] SRC_PIN_B = 7'h01;
	localparam logic [6:0] SRC_PIN_C = 7'h02;
	localparam logic [6:0] SRC_PIN_D = 7'h04;
	localparam logic [6:0] SRC_BG = 7'h08;
	localparam logic [6:0] SRC_BG2 = 7'h10;
	localparam logic [6:0] SRC_BG6 = 7'h20;
	localparam logic [6:0] SRC_EXTREF = 7'h40;
	// One-hot source codes for the non-inverting input
	localparam logic [2:0] PLUS_PIN_A = 3'h1;
	localparam logic [2:0] PLUS_LADDER = 3'h2;
	localparam logic [2:0] PLUS_EXTREF = 3'h4;

endpackage : cmp_pkg

// ==== comparator_unit.sv ====
/*
 * One comparator's digital side: output synchroniser, polarity,
 * edge detection and the latched event flag.
 * Assumes rawResult comes asynchronously from the analog core.
 */
module comparator_unit
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Analog side
	input wire logic rawResult,
	// Configuration
	input wire logic active,
	input wire logic invert,
	input wire logic [1:0] edgeSel,
	// Software access to the event flag
	input wire logic evtWrEn,
	input wire logic evtWrData,
	// Status
	output logic resultBit,
	output logic eventLatched
);

	// ********************************************************
	// State
	// ********************************************************
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic prev;
		logic evt;
	} unit_s;

	unit_s s_q;
	unit_s s_d;
	logic adjusted;
	logic rise;
	logic fall;
	logic trigger;

	// Polarity-adjusted output and its edges
	assign adjusted = active & (s_q.sync2 ^ invert);
	assign rise = adjusted & ~s_q.prev;
	assign fall = ~adjusted & s_q.prev;
	assign resultBit = adjusted;
	assign eventLatched = s_q.evt;

	// Edge selection, no trigger for EDGE_NONE
	always_comb
	begin
		case (edgeSel)
			cmp_pkg::EDGE_RISE: trigger = rise;
			cmp_pkg::EDGE_FALL: trigger = fall;
			cmp_pkg::EDGE_ANY: trigger = rise | fall;
			default: trigger = 1'b0;
		endcase
	end

	// Next state: synchroniser, edge history, event flag
	always_comb
	begin
		s_d = s_q;
		s_d.sync1 = rawResult;
		s_d.sync2 = s_q.sync1;
		s_d.prev = adjusted;
		if (evtWrEn)
		begin
			s_d.evt = evtWrData;
		end
		// Hardware set wins over a software write only while the flag is clear
		if (active && trigger && !s_q.evt)
		begin
			s_d.evt = 1'b1;
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence rawHighSteady;
		(rawResult && active && !invert)[*3];
	endsequence

	property evt_held;
		eventLatched && !evtWrEn |=> eventLatched;
	endproperty

	a_sync_result: assert property (rawHighSteady |-> resultBit)
		else $error("result did not follow raw input after sync");
	a_event_hold: assert property (evt_held)
		else $error("event flag dropped without software clear");
	a_rise_sets: assert property (active && edgeSel == cmp_pkg::EDGE_RISE
		&& rise && !s_q.evt |=> eventLatched)
		else $error("rising edge did not latch event");
	a_trig_off: assert property (edgeSel == cmp_pkg::EDGE_NONE
		&& !eventLatched && !evtWrEn |=> !eventLatched)
		else $error("event set with triggering disabled");
	a_off_quiet: assert property (!active |-> !resultBit)
		else $error("disabled comparator reports output");

endmodule : comparator_unit

// ==== triple_comparator_control.sv ====
/*
 * Triple comparator control: APB register file, input routing selects,
 * polarity, pin drive, event latching and idle stop for three units.
 * Assumes analog cores that take the routing selects and return raw
 * asynchronous results, and an idle indication on the system clock.
 */
module triple_comparator_control
#(
	parameter int UNITS = 3
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Power state
	input wire logic idleMode,
	// Analog cores
	input wire logic [UNITS-1:0] rawResult,
	output logic [UNITS-1:0] cmpActive,
	output logic [UNITS-1:0][2:0] plusRoute,
	output logic [UNITS-1:0][6:0] minusRoute,
	// Result pins
	output logic [UNITS-1:0] resultPin,
	output logic [UNITS-1:0] resultPinOe
);

	// ********************************************************
	// Decoders
	// ********************************************************
	// Non-inverting source from plus select and reference pin select
	function automatic logic [2:0] decodePlus(input logic refSel,
		input logic extPin);
		if (!refSel)
		begin
			return cmp_pkg::PLUS_PIN_A;
		end
		else if (extPin)
		begin
			return cmp_pkg::PLUS_EXTREF;
		end
		else
		begin
			return cmp_pkg::PLUS_LADDER;
		end
	endfunction : decodePlus

	// Inverting source from channel select and band gap select
	function automatic logic [6:0] decodeMinus(input logic [1:0] ch,
		input logic [1:0] bg);
		logic [6:0] r;
		r = cmp_pkg::SRC_PIN_B;
		case (ch)
			cmp_pkg::MINUS_PIN_B: r = cmp_pkg::SRC_PIN_B;
			cmp_pkg::MINUS_PIN_C: r = cmp_pkg::SRC_PIN_C;
			cmp_pkg::MINUS_PIN_D: r = cmp_pkg::SRC_PIN_D;
			default:
			begin
				case (bg)
					cmp_pkg::BG_FULL: r = cmp_pkg::SRC_BG;
					cmp_pkg::BG_HALF: r = cmp_pkg::SRC_BG2;
					cmp_pkg::BG_SIXTH: r = cmp_pkg::SRC_BG6;
					default: r = cmp_pkg::SRC_EXTREF;
				endcase
			end
		endcase
		return r;
	endfunction : decodeMinus

	// ********************************************************
	// State
	// ********************************************************
	typedef struct packed {
		logic [UNITS-1:0][15:0] ctrl;
		logic idleHalt;
		logic [2:0] refSel;
		logic [31:0] rdata;
		logic rdErr;
		logic [UNITS-1:0][2:0] plus;
		logic [UNITS-1:0][6:0] minus;
	} ctl_s;

	ctl_s s_q;
	ctl_s s_d;
	logic [UNITS-1:0] resultBit;
	logic [UNITS-1:0] eventLatched;
	logic [UNITS-1:0] evtWrEn;
	logic [UNITS-1:0] active;
	logic [UNITS-1:0] invert;
	logic accessDone;
	logic [15:0] statWord;

	// Access phase completes at once; read data prepared at setup
	assign accessDone = psel & penable;
	assign pready = accessDone;
	assign pslverr = accessDone & s_q.rdErr;
	assign prdata = s_q.rdata;
	assign plusRoute = s_q.plus;
	assign minusRoute = s_q.minus;

	// Status word: idle halt, event copies, result copies
	always_comb
	begin
		statWord = cmp_pkg::STAT_RESET;
		statWord[cmp_pkg::IDLE_HALT_BIT] = s_q.idleHalt;
		statWord[cmp_pkg::STAT_EVT_LO +: 3] = eventLatched;
		statWord[cmp_pkg::STAT_OUT_LO +: 3] = resultBit;
	end

	// ********************************************************
	// Per-comparator logic
	// ********************************************************
	genvar gi;
	generate
		for (gi = 0; gi < UNITS; gi++)
		begin : g_unit
			// Enabled and not halted by idle
			assign active[gi] = s_q.ctrl[gi][cmp_pkg::CMP_ON_BIT]
				& ~(idleMode & s_q.idleHalt);
			assign invert[gi] = s_q.ctrl[gi][cmp_pkg::INVERT_BIT];
			assign cmpActive[gi] = active[gi];
			assign evtWrEn[gi] = accessDone & pwrite
				& (paddr == 8'(gi * 4));
			// Unsynchronized, polarity-adjusted pin drive
			assign resultPinOe[gi] = active[gi]
				& s_q.ctrl[gi][cmp_pkg::PIN_DRIVE_BIT];
			assign resultPin[gi] = resultPinOe[gi]
				& (rawResult[gi] ^ invert[gi]);

			comparator_unit u_unit
			(
				.sys_clk(sys_clk),
				.rst(rst),
				.rawResult(rawResult[gi]),
				.active(active[gi]),
				.invert(invert[gi]),
				.edgeSel(s_q.ctrl[gi][cmp_pkg::EDGE_HI:cmp_pkg::EDGE_LO]),
				.evtWrEn(evtWrEn[gi]),
				.evtWrData(pwdata[cmp_pkg::EVENT_BIT]),
				.resultBit(resultBit[gi]),
				.eventLatched(eventLatched[gi])
			);
		end
	endgenerate

	// ********************************************************
	// Register file and routing
	// ********************************************************
	always_comb
	begin
		s_d = s_q;
		// Writes take effect in the access phase
		if (accessDone && pwrite)
		begin
			if (paddr == cmp_pkg::OFS_CTRL1)
			begin
				s_d.ctrl[0] = pwdata[15:0] & cmp_pkg::CTRL_WMASK;
			end
			else if (paddr == cmp_pkg::OFS_CTRL2)
			begin
				s_d.ctrl[1] = pwdata[15:0] & cmp_pkg::CTRL_WMASK;
			end
			else if (paddr == cmp_pkg::OFS_CTRL3)
			begin
				s_d.ctrl[2] = pwdata[15:0] & cmp_pkg::CTRL_WMASK;
			end
			else if (paddr == cmp_pkg::OFS_STAT)
			begin
				s_d.idleHalt = pwdata[cmp_pkg::IDLE_HALT_BIT];
			end
			else if (paddr == cmp_pkg::OFS_REFSEL)
			begin
				s_d.refSel = pwdata[cmp_pkg::EXT_REF_BIT:cmp_pkg::BG_SRC_LO];
			end
		end
		// Read data and error prepared in the setup phase, held to the next
		if (psel && !penable)
		begin
			s_d.rdErr = 1'b0;
			s_d.rdata = '0;
			if (paddr == cmp_pkg::OFS_CTRL1 || paddr == cmp_pkg::OFS_CTRL2
				|| paddr == cmp_pkg::OFS_CTRL3)
			begin
				for (int i = 0; i < UNITS; i++)
				begin
					if (paddr == 8'(i * 4))
					begin
						s_d.rdata[15:0] = s_q.ctrl[i];
						s_d.rdata[cmp_pkg::EVENT_BIT] = eventLatched[i];
						s_d.rdata[cmp_pkg::RESULT_BIT] = resultBit[i];
					end
				end
			end
			else if (paddr == cmp_pkg::OFS_STAT)
			begin
				s_d.rdata[15:0] = statWord;
			end
			else if (paddr == cmp_pkg::OFS_REFSEL)
			begin
				s_d.rdata[cmp_pkg::EXT_REF_BIT:cmp_pkg::BG_SRC_LO] = s_q.refSel;
			end
			else
			begin
				s_d.rdErr = 1'b1;
			end
		end
		// Analog routing selects
		for (int i = 0; i < UNITS; i++)
		begin
			s_d.plus[i] = decodePlus(s_q.ctrl[i][cmp_pkg::PLUS_SEL_BIT],
				s_q.refSel[2]);
			s_d.minus[i] = decodeMinus(
				s_q.ctrl[i][cmp_pkg::MINUS_HI:cmp_pkg::MINUS_LO],
				s_q.refSel[1:0]);
		end
	end

	// State register
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			s_q <= '0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	sequence statSetup;
		psel && !penable && paddr == cmp_pkg::OFS_STAT;
	endsequence

	a_idle_halt: assert property (@(posedge sys_clk) disable iff (rst)
		idleMode && s_q.idleHalt |-> cmpActive == '0)
		else $error("comparator active while halted in idle");
	a_stat_events: assert property (@(posedge sys_clk) disable iff (rst)
		statSetup |=> prdata[10:8] == $past(eventLatched))
		else $error("status event copies wrong");
	a_stat_results: assert property (@(posedge sys_clk) disable iff (rst)
		statSetup |=> prdata[2:0] == $past(resultBit))
		else $error("status result copies wrong");
	a_pin_drive: assert property (@(posedge sys_clk) disable iff (rst)
		active[0] && s_q.ctrl[0][cmp_pkg::PIN_DRIVE_BIT]
		|-> resultPin[0] == (rawResult[0] ^ invert[0]))
		else $error("pin does not show raw result");
	a_plus_route: assert property (@(posedge sys_clk) disable iff (rst)
		!s_q.ctrl[0][cmp_pkg::PLUS_SEL_BIT] ##1
		!s_q.ctrl[0][cmp_pkg::PLUS_SEL_BIT]
		|=> plusRoute[0] == cmp_pkg::PLUS_PIN_A)
		else $error("plus input not routed to pin A");

endmodule : triple_comparator_control

// ==== cmp_analog_model.sv ====
/*
 * Behavioural model of the three analog comparator cores and their
 * input pins, references and band gap levels.
 * Assumes levels in millivolts from the bench and the one-hot route
 * codes of the control block.
 */
module cmp_analog_model
(
	// Clock for the unpowered output pattern
	input wire logic sys_clk,
	// Analog levels from the bench
	input wire logic [11:0] vPinA,
	input wire logic [11:0] vPinB,
	input wire logic [11:0] vPinC,
	input wire logic [11:0] vPinD,
	input wire logic [11:0] vLadder,
	input wire logic [11:0] vExtRef,
	input wire logic [11:0] vBand,
	// Control block side
	input wire logic [2:0] cmpActive,
	input wire logic [2:0][2:0] plusRoute,
	input wire logic [2:0][6:0] minusRoute,
	output logic [2:0] rawResult
);
	timeunit 1ns;
	timeprecision 1ns;

	logic wobble = 1'b0;
	logic [2:0][11:0] vPlus;
	logic [2:0][11:0] vMinus;

	// An unpowered core gives no steady level
	always @(posedge sys_clk) wobble <= ~wobble;

	// Input muxes and the comparison itself
	always_comb
	begin
		for (int u = 0; u < 3; u++)
		begin
			vPlus[u] = plusRoute[u][0] ? vPinA :
				plusRoute[u][1] ? vLadder : vExtRef;
			vMinus[u] = minusRoute[u][0] ? vPinB :
				minusRoute[u][1] ? vPinC :
				minusRoute[u][2] ? vPinD :
				minusRoute[u][3] ? vBand :
				minusRoute[u][4] ? vBand / 2 :
				minusRoute[u][5] ? vBand / 6 : vExtRef;
			rawResult[u] = cmpActive[u] ? (vPlus[u] > vMinus[u]) : wobble;
		end
	end

endmodule : cmp_analog_model

// ==== tb_top.sv ====
/*
 * Self-checking bench for the triple comparator control block.
 * Assumes the analog model drives rawResult and a 50 MHz system clock.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, idleMode = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd, x;
	logic pready, pslverr, err;
	logic [2:0] rawResult, cmpActive, resultPin, resultPinOe;
	logic [2:0][2:0] plusRoute;
	logic [2:0][6:0] minusRoute;
	logic [11:0] vA = 12'h100;
	logic [11:0] vB = 12'h200, vR = 12'h400, bandgap_level = 12'h4B0;
	int n_mismatch = 0, samples_checked = 0;
	logic [7:0] ctl;

	always #10 sys_clk = ~sys_clk;

	triple_comparator_control #(.UNITS(3)) dut_u (.sys_clk(sys_clk),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .idleMode(idleMode), .rawResult(rawResult),
		.cmpActive(cmpActive), .plusRoute(plusRoute),
		.minusRoute(minusRoute), .resultPin(resultPin),
		.resultPinOe(resultPinOe));

	cmp_analog_model mdl_u (.sys_clk(sys_clk), .vPinA(vA),
		.vPinB(vB), .vPinC(12'h300), .vPinD(12'h050),
		.vLadder(12'h180), .vExtRef(vR), .vBand(bandgap_level),
		.cmpActive(cmpActive), .plusRoute(plusRoute),
		.minusRoute(minusRoute), .rawResult(rawResult));

	// ********************************************************
	// Tasks
	// ********************************************************
	task test_done;
		$display("Counts: %0d checked, %0d mismatched", samples_checked,
			n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : test_done

	task chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// One APB transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			$display("[FAIL] pready expected 1 seen %b", pready);
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rdc(input string name, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(name, e, rd);
	endtask : rdc

	task settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask : settle

	// ********************************************************
	// Main sequence
	// ********************************************************
	initial
	begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		for (int u = 0; u < 5; u++)
			rdc("reset value", 8'(4 * u), 32'h0);
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped error", 32'h1, 32'(err));
		chk("unmapped data", 32'h0, rd);
		$display("Test reset done");
		for (int u = 0; u < 3; u++)
		begin
			ctl = cmp_pkg::OFS_CTRL1 + 8'(4 * u);
			for (int i = 0; i < 7; i++)
			begin
				wr(cmp_pkg::OFS_REFSEL, (i < 3) ? 32'h0 : 32'(i - 3) << 8);
				wr(ctl, 32'h8000 | ((i < 3) ? 32'(i) : 32'h3));
				settle(1);
				chk("minus route", 32'h1 << i, 32'(minusRoute[u]));
				chk("unit active", 32'h1, 32'(cmpActive[u]));
			end
			for (int j = 0; j < 3; j++)
			begin
				wr(cmp_pkg::OFS_REFSEL, (j == 2) ? 32'h400 : 32'h0);
				wr(ctl, (j > 0) ? 32'h8010 : 32'h8000);
				settle(1);
				chk("plus route", 32'h1 << j, 32'(plusRoute[u]));
			end
			wr(ctl, 32'h0);
			settle(1);
			chk("unit off", 32'h0, 32'(cmpActive[u]));
		end
		$display("Test routing done");
		wr(cmp_pkg::OFS_REFSEL, 32'h0);
		for (int e = 0; e < 4; e++)
		begin
			vA = 12'h100;
			wr(cmp_pkg::OFS_CTRL1, 32'h8000 | (32'(e) << 6));
			settle(4);
			vA = 12'h300;
			settle(4);
			x = 32'h8100 | (32'(e) << 6) | (e[0] ? 32'h200 : 32'h0);
			rdc("event on rise", cmp_pkg::OFS_CTRL1, x);
			rdc("status copies", cmp_pkg::OFS_STAT,
				32'h1 | (32'(x[9]) << 8));
			vA = 12'h100;
			settle(4);
			x = 32'h8000 | (32'(e) << 6) | ((e != 0) ? 32'h200 : 32'h0);
			rdc("event on fall", cmp_pkg::OFS_CTRL1, x);
			wr(cmp_pkg::OFS_CTRL1, 32'h8000 | (32'(e) << 6));
			settle(1);
			rdc("event cleared", cmp_pkg::OFS_CTRL1, x & ~32'h200);
		end
		$display("Test events done");
		vA = 12'h300;
		settle(4);
		wr(cmp_pkg::OFS_CTRL1, 32'hE000);
		settle(4);
		rdc("inverted result", cmp_pkg::OFS_CTRL1, 32'hE000);
		chk("pin enable", 32'h1, 32'(resultPinOe[0]));
		chk("pin level", 32'h0, 32'(resultPin[0]));
		wr(cmp_pkg::OFS_CTRL1, 32'hC000);
		settle(4);
		rdc("plain result", cmp_pkg::OFS_CTRL1, 32'hC100);
		chk("pin level", 32'h1, 32'(resultPin[0]));
		wr(cmp_pkg::OFS_CTRL1, 32'h8000);
		settle(1);
		chk("pin enable", 32'h0, 32'(resultPinOe[0]));
		$display("Test pin done");
		@(posedge sys_clk) idleMode <= 1'b1;
		settle(2);
		chk("active in idle", 32'h1, 32'(cmpActive[0]));
		wr(cmp_pkg::OFS_STAT, 32'hFFFF);
		settle(4);
		rdc("halted status", cmp_pkg::OFS_STAT, 32'h8000);
		chk("halted unit", 32'h0, 32'(cmpActive[0]));
		@(posedge sys_clk) idleMode <= 1'b0;
		settle(4);
		rdc("resumed status", cmp_pkg::OFS_STAT, 32'h8001);
		wr(cmp_pkg::OFS_CTRL3, 32'h8040);
		settle(4);
		rdc("unit3 status", cmp_pkg::OFS_STAT, 32'h8405);
		$display("Test idle done");
		test_done();
	end

endmodule : tb_top
